//--- core/tfw_cfg.svh
// Constants for the transmit FIFO flag and scheduler guard block.
// Assumes one 250 MHz clock; included by bare name from core/.
`ifndef TFW_CFG_SVH
`define TFW_CFG_SVH
`define TFW_NCH 8
`define TFW_A_FLAGS 16'h800F
`define TFW_A_IRQEN 16'h804F
`define TFW_A_THR 16'h8060
`define TFW_A_CNT 16'h8080
`define TFW_A_MASK 16'h807E
`define TFW_A_CDN 16'h807F
`define TFW_OP_FAST 8'h3C
`define TFW_DEPTH 6'h20
`define TFW_RST_FLAG 1'h1
`define TFW_RST_IRQEN 8'h00
`define TFW_RST_THR 5'h00
`define TFW_RST_MASK 8'hFF
`define TFW_RST_CDN 8'h00
`define TFW_MASK_ALL 8'hFF
`define TFW_TICK_MS 20
`define TFW_CLK_KHZ 250000
`define TFW_TICK_CYC (`TFW_TICK_MS * `TFW_CLK_KHZ)
`endif

//--- core/tfw_pkg.sv
// Types for the transmit FIFO flag and scheduler guard block.
// Assumes the register front end delivers decoded byte accesses.
package tfw_pkg;
	// Guard arming sequence, one-hot
	typedef enum logic [3:0] {
		GUARD_IDLE = 4'b0001,
		GUARD_PRIMED = 4'b0010,
		GUARD_LOADED = 4'b0100,
		GUARD_ARMED = 4'b1000
	} tfw_guard_e;
	// One register access from the serial front end
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [7:0] wdata;
	} tfw_reg_req_s;
	// Registered answer to a read
	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} tfw_reg_rsp_s;
endpackage

//--- core/tfw_chan.sv
// One transmit channel: message count, full refusal and level flag.
// Assumes push and pop strobes come from logic on the same clock.
`timescale 1ns/1ns
`include "tfw_cfg.svh"
module tfw_chan (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// FIFO traffic
	input wire logic wr_i,
	input wire logic pop_i,
	output logic accept_o,
	// Setup
	input wire logic [4:0] thr_i,
	input wire logic en_i,
	// Status
	output logic [5:0] count_o,
	output logic flag_o,
	output logic rise_o
);
	logic [5:0] next_count;
	logic next_flag;
	wire full = (count_o == `TFW_DEPTH);
	wire pop_ok = pop_i && (count_o != 6'h00);

	// Full FIFO refuses the push, so the count never passes the depth
	assign accept_o = wr_i && !full && ce_i;
	assign next_count = count_o + {5'h00, accept_o} - {5'h00, pop_ok};
	// Compare against the new count so flag and count move together
	assign next_flag = (next_count <= {1'b0, thr_i});
	assign rise_o = ce_i && en_i && next_flag && !flag_o;

	// Count and flag registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_o <= 6'h00;
			flag_o <= `TFW_RST_FLAG;
		end else if (ce_i) begin
			count_o <= next_count;
			flag_o <= next_flag;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	chk_full_refused: assert property (full && wr_i && !pop_i |=> $stable(count_o))
		else $error("push into full FIFO changed the count");
	chk_flag_follows: assert property (ce_i |=> flag_o == (count_o <= {1'b0, $past(thr_i)}))
		else $error("level flag does not match count and threshold");
	chk_count_bound: assert property (count_o <= `TFW_DEPTH)
		else $error("message count above depth");
endmodule

//--- core/tfw_top.sv
// Transmit FIFO level flags, counts, level event and scheduler guard.
// Assumes a serial front end on clk_i hands over decoded byte accesses,
// and transmitters report pops and frame ends on the same clock.
`timescale 1ns/1ns
`include "tfw_cfg.svh"
module tfw_top import tfw_pkg::*; #(
	parameter int TICK_CYCLES = `TFW_TICK_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic soft_reset_i,
	// Register access
	input wire tfw_reg_req_s reg_req_i,
	output tfw_reg_rsp_s reg_rsp_o,
	// Fast flag poll
	input wire logic fast_op_valid_i,
	input wire logic [7:0] fast_op_i,
	output logic fast_ack_o,
	output logic [7:0] fast_flags_o,
	// FIFO traffic
	input wire logic [7:0] host_wr_i,
	output logic [7:0] host_wr_accept_o,
	input wire logic [7:0] fifo_pop_i,
	// Schedulers
	input wire logic [7:0] frame_end_i,
	output logic [7:0] sched_stop_o,
	// Pending event and interrupt
	input wire logic pending_tx_level_event_en_i,
	input wire logic pend_clr_i,
	output logic pending_tx_level_event_o,
	output logic int_n_o,
	// Guard status
	output logic guard_armed_o,
	output logic guard_expired_o
);
	localparam int PW = $clog2(TICK_CYCLES + 1);

	logic [7:0][4:0] thr;
	logic [7:0][5:0] cnt;
	logic [7:0] flags;
	logic [7:0] rise;
	logic [7:0] irq_en;
	logic [7:0] guard_mask;
	logic [7:0] guard_countdown;
	logic [7:0] next_countdown;
	logic [7:0] next_stop;
	logic [7:0] rd_mux;
	logic [PW-1:0] presc;
	logic next_expired;
	logic next_pend;
	tfw_guard_e state;
	tfw_guard_e next_state;

	// Access decode
	wire [15:0] addr = reg_req_i.addr;
	wire [7:0] wdata = reg_req_i.wdata;
	wire [2:0] idx = addr[2:0];
	wire wr = reg_req_i.wr;
	wire hit_thr = (addr[15:3] == 13'(`TFW_A_THR >> 3));
	wire hit_cnt = (addr[15:3] == 13'(`TFW_A_CNT >> 3));
	wire wr_irqen = wr && (addr == `TFW_A_IRQEN);
	wire wr_thr = wr && hit_thr;
	wire wr_mask = wr && (addr == `TFW_A_MASK);
	wire wr_cdn = wr && (addr == `TFW_A_CDN);
	wire mask_all = (wdata == `TFW_MASK_ALL);
	wire resume = wr_cdn && (wdata != 8'h00);

	// Read selection; unmapped addresses read zero
	assign rd_mux = (addr == `TFW_A_FLAGS) ? flags :
		(addr == `TFW_A_IRQEN) ? irq_en :
		hit_thr ? {3'h0, thr[idx]} :
		hit_cnt ? {2'h0, cnt[idx]} :
		(addr == `TFW_A_MASK) ? guard_mask :
		(addr == `TFW_A_CDN) ? guard_countdown : 8'h00;

	// Per-channel count, refusal and flag
	for (genvar g = 0; g < `TFW_NCH; g++) begin : g_ch
		tfw_chan u_ch (
			.clk_i(clk_i),
			.resetn_i(resetn_i),
			.ce_i(ce_i),
			.wr_i(host_wr_i[g]),
			.pop_i(fifo_pop_i[g]),
			.accept_o(host_wr_accept_o[g]),
			.thr_i(thr[g]),
			.en_i(irq_en[g]),
			.count_o(cnt[g]),
			.flag_o(flags[g]),
			.rise_o(rise[g])
		);
	end

	// Setup registers; software reset returns them to defaults
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_en <= `TFW_RST_IRQEN;
			thr <= {`TFW_NCH{`TFW_RST_THR}};
			guard_mask <= `TFW_RST_MASK;
		end else if (ce_i) begin
			if (soft_reset_i) begin
				irq_en <= `TFW_RST_IRQEN;
				thr <= {`TFW_NCH{`TFW_RST_THR}};
				guard_mask <= `TFW_RST_MASK;
			end else begin
				if (wr_irqen) irq_en <= wdata;
				if (wr_thr) thr[idx] <= wdata[4:0];
				if (wr_mask) guard_mask <= wdata;
			end
		end
	end

	// Read answer and fast poll, both one cycle after the request
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			reg_rsp_o <= '0;
			fast_ack_o <= 1'b0;
			fast_flags_o <= 8'h00;
		end else if (ce_i) begin
			reg_rsp_o.ack <= reg_req_i.rd;
			reg_rsp_o.data <= reg_req_i.rd ? rd_mux : 8'h00;
			fast_ack_o <= fast_op_valid_i && (fast_op_i == `TFW_OP_FAST);
			fast_flags_o <= flags;
		end
	end

	// Arming sequence; an armed guard stays armed until reset, but a mask write still changes guard_mask
	always_comb begin
		next_state = state;
		unique case (state)
			GUARD_IDLE: begin
				if (wr_mask && mask_all) next_state = GUARD_PRIMED;
			end
			GUARD_PRIMED: begin
				if (wr_cdn) next_state = GUARD_LOADED;
				else if (wr_mask && !mask_all) next_state = GUARD_IDLE;
			end
			GUARD_LOADED: begin
				if (wr_mask) next_state = mask_all ? GUARD_PRIMED : GUARD_ARMED;
			end
			GUARD_ARMED: begin
				next_state = GUARD_ARMED;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) state <= GUARD_IDLE;
		else if (ce_i) state <= soft_reset_i ? GUARD_IDLE : next_state;
	end

	assign guard_armed_o = (state == GUARD_ARMED);

	// Tick prescaler restarts on each refresh so a refresh buys a full count
	wire tick = guard_armed_o && (presc == PW'(TICK_CYCLES - 1));
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) presc <= '0;
		else if (ce_i) presc <= (!guard_armed_o || wr_cdn || tick) ? '0 : presc + PW'(1);
	end

	// Countdown: host load, otherwise one step per tick while armed
	assign next_countdown = wr_cdn ? wdata :
		(tick && guard_countdown != 8'h00) ? guard_countdown - 8'h01 : guard_countdown;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) guard_countdown <= `TFW_RST_CDN;
		else if (ce_i) guard_countdown <= soft_reset_i ? `TFW_RST_CDN : next_countdown;
	end

	// Expiry once an armed countdown sits at zero; a non-zero load lifts it
	assign next_expired = !resume &&
		(guard_expired_o || (guard_armed_o && guard_countdown == 8'h00 && !wr_cdn));
	// Supervised schedulers stop only at their own frame end
	assign next_stop = resume ? 8'h00 :
		sched_stop_o | ({8{guard_expired_o}} & frame_end_i & ~guard_mask);
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			guard_expired_o <= 1'b0;
			sched_stop_o <= 8'h00;
		end else if (ce_i) begin
			guard_expired_o <= soft_reset_i ? 1'b0 : next_expired;
			sched_stop_o <= soft_reset_i ? 8'h00 : next_stop;
		end
	end

	// Pending level event: a new rising wins over a clear in the same cycle
	assign next_pend = (|rise) || (pending_tx_level_event_o && !pend_clr_i);
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pending_tx_level_event_o <= 1'b0;
			int_n_o <= 1'b1;
		end else if (ce_i) begin
			pending_tx_level_event_o <= next_pend;
			int_n_o <= !(pending_tx_level_event_o && pending_tx_level_event_en_i);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	chk_guard_stays_armed: assert property (guard_armed_o && !soft_reset_i |=> guard_armed_o)
		else $error("armed guard was disarmed without reset");
	chk_arm_sequence: assert property (ce_i && state == GUARD_LOADED && wr_mask && !mask_all
		|=> guard_armed_o)
		else $error("guard did not arm after the third step");
	chk_idle_no_count: assert property (!guard_armed_o && !wr_cdn && !soft_reset_i
		|=> $stable(guard_countdown))
		else $error("countdown moved while guard is off");
	chk_tick_step: assert property (ce_i && tick && !wr_cdn && !soft_reset_i && guard_countdown != 8'h00
		|=> guard_countdown == $past(guard_countdown) - 8'h01)
		else $error("countdown did not drop by one on a tick");
	chk_stop_at_frame: assert property (ce_i |=> ((sched_stop_o & ~$past(sched_stop_o)
		& ~($past(frame_end_i) & ~$past(guard_mask))) == 8'h00))
		else $error("scheduler stopped outside a supervised frame end");
	chk_resume_clears: assert property (ce_i && resume && !soft_reset_i
		|=> !guard_expired_o && sched_stop_o == 8'h00)
		else $error("non-zero countdown load did not restart schedulers");
	chk_irq_gate: assert property (!int_n_o |-> $past(pending_tx_level_event_o)
		&& $past(pending_tx_level_event_en_i))
		else $error("interrupt driven without an enabled pending event");
	chk_event_set: assert property (|rise |=> pending_tx_level_event_o)
		else $error("enabled flag rising did not raise the pending event");
	chk_fast_poll: assert property (ce_i && fast_op_valid_i && fast_op_i == `TFW_OP_FAST
		|=> fast_ack_o && fast_flags_o == $past(flags))
		else $error("fast poll answer missing or wrong");

	cov_armed: cover property (!guard_armed_o ##1 guard_armed_o);
	cov_expiry: cover property (!guard_expired_o ##1 guard_expired_o);
	cov_stop: cover property (sched_stop_o == 8'h00 ##1 sched_stop_o != 8'h00);
	cov_event: cover property (!pending_tx_level_event_o ##1 !int_n_o);
endmodule

//--- bench/tfw_host.sv
// Host model on the far side: byte register accesses and fast flag polls.
// Assumes the decoded byte port of tfw_top and one shared clock.
`timescale 1ns/1ns
`include "tfw_cfg.svh"
module tfw_host import tfw_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Register link
	output tfw_reg_req_s req_o,
	input wire tfw_reg_rsp_s rsp_i,
	// Fast poll
	output logic fast_valid_o,
	output logic [7:0] fast_op_o,
	input wire logic fast_ack_i,
	input wire logic [7:0] fast_flags_i
);
	initial begin
		req_o = '0;
		fast_valid_o = 1'b0;
		fast_op_o = 8'h00;
	end
	// Released fields show the inverse so stale values cannot pass
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Answer stands only for the cycle after the taking edge, so it is read inside that cycle
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ack);
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		#1;
		d = rsp_i.data;
		ack = rsp_i.ack;
	endtask
	// Fast poll of the flag byte
	task automatic poll(output logic [7:0] d, output logic ack);
		@(posedge clk_i);
		fast_valid_o <= 1'b1;
		fast_op_o <= `TFW_OP_FAST;
		@(posedge clk_i);
		fast_valid_o <= 1'b0;
		fast_op_o <= 8'hC3;
		#1;
		d = fast_flags_i;
		ack = fast_ack_i;
	endtask
	// Arming needs these three writes in this order
	task automatic arm(input logic [7:0] cdn, input logic [7:0] mask);
		wr(`TFW_A_MASK, `TFW_MASK_ALL);
		wr(`TFW_A_CDN, cdn);
		wr(`TFW_A_MASK, mask);
	endtask
endmodule

//--- bench/tb.sv
// Self-checking bench for tfw_top with a short guard tick.
// Assumes tfw_host as the register master and a 250 MHz clock.
`timescale 1ns/1ns
`include "tfw_cfg.svh"
module tb import tfw_pkg::*; ;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic soft_reset_i = 1'b0;
	logic [7:0] host_wr = 8'h00;
	logic [7:0] pop = 8'h00;
	logic [7:0] frame_end = 8'h00;
	logic pend_en = 1'b0;
	logic pend_clr = 1'b0;
	tfw_reg_req_s req;
	tfw_reg_rsp_s rsp;
	logic fvalid, fack, pending, int_n, armed, expired;
	logic [7:0] fop, fflags, accept, stop;
	int checks = 0;
	int miscompares = 0;
	// Short tick keeps the guard run to a few dozen cycles
	tfw_top #(.TICK_CYCLES(8)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
		.soft_reset_i(soft_reset_i), .reg_req_i(req), .reg_rsp_o(rsp), .fast_op_valid_i(fvalid),
		.fast_op_i(fop), .fast_ack_o(fack), .fast_flags_o(fflags), .host_wr_i(host_wr),
		.host_wr_accept_o(accept), .fifo_pop_i(pop), .frame_end_i(frame_end), .sched_stop_o(stop),
		.pending_tx_level_event_en_i(pend_en), .pend_clr_i(pend_clr),
		.pending_tx_level_event_o(pending), .int_n_o(int_n), .guard_armed_o(armed),
		.guard_expired_o(expired));
	tfw_host i_host (.clk_i(clk_i), .req_o(req), .rsp_i(rsp), .fast_valid_o(fvalid),
		.fast_op_o(fop), .fast_ack_i(fack), .fast_flags_i(fflags));
	always #2 clk_i = ~clk_i;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ack;
		i_host.rd(a, d, ack);
		check({7'h00, ack}, 8'h01);
		check(d, exp);
	endtask
	// Strobes held for n taking edges, then settled
	task automatic drive(input bit is_pop, input int ch, input int n);
		@(posedge clk_i);
		if (is_pop) pop <= 8'h01 << ch;
		else host_wr <= 8'h01 << ch;
		repeat (n) @(posedge clk_i);
		pop <= 8'h00;
		host_wr <= 8'h00;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic t_reset();
		rchk(`TFW_A_FLAGS, 8'hFF);
		i_host.wr(`TFW_A_FLAGS, 8'h00);
		i_host.wr(`TFW_A_CNT + 16'h0007, 8'h05);
		rchk(`TFW_A_FLAGS, 8'hFF);
		rchk(`TFW_A_CNT + 16'h0007, 8'h00);
		rchk(`TFW_A_IRQEN, `TFW_RST_IRQEN);
		rchk(`TFW_A_THR + 16'h0005, 8'h00);
		rchk(`TFW_A_MASK, `TFW_RST_MASK);
		rchk(`TFW_A_CDN, `TFW_RST_CDN);
		rchk(16'h8050, 8'h00);
		check({7'h00, armed}, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_level();
		logic [7:0] d;
		logic ack;
		drive(1'b0, 2, 3);
		rchk(`TFW_A_CNT + 16'h0002, 8'h03);
		i_host.wr(`TFW_A_THR + 16'h0002, 8'h02);
		rchk(`TFW_A_FLAGS, 8'hFB);
		i_host.wr(`TFW_A_THR + 16'h0002, 8'h03);
		rchk(`TFW_A_FLAGS, 8'hFF);
		i_host.poll(d, ack);
		check({7'h00, ack}, 8'h01);
		check(d, 8'hFF);
		$display("test level done");
	endtask
	task automatic t_full();
		drive(1'b0, 0, 33);
		@(posedge clk_i);
		host_wr <= 8'h01;
		#1;
		check(accept, 8'h00);
		@(posedge clk_i);
		host_wr <= 8'h00;
		rchk(`TFW_A_CNT, 8'h20);
		i_host.wr(`TFW_A_THR, 8'h1F);
		rchk(`TFW_A_FLAGS, 8'hFE);
		drive(1'b1, 0, 1);
		rchk(`TFW_A_FLAGS, 8'hFF);
		drive(1'b1, 0, 31);
		rchk(`TFW_A_CNT, 8'h00);
		$display("test full done");
	endtask
	task automatic t_event();
		drive(1'b0, 1, 1);
		i_host.wr(`TFW_A_IRQEN, 8'h02);
		pend_en <= 1'b1;
		drive(1'b1, 1, 1);
		check({6'h00, pending, int_n}, 8'h02);
		@(posedge clk_i);
		pend_clr <= 1'b1;
		repeat (4) @(posedge clk_i);
		pend_clr <= 1'b0;
		pend_en <= 1'b0;
		#1;
		check({6'h00, pending, int_n}, 8'h01);
		drive(1'b0, 1, 1);
		drive(1'b1, 1, 1);
		check({6'h00, pending, int_n}, 8'h03);
		$display("test event done");
	endtask
	task automatic t_guard();
		i_host.arm(8'h02, 8'hFE);
		repeat (2) @(posedge clk_i);
		#1;
		check({7'h00, armed}, 8'h01);
		repeat (6) @(posedge clk_i);
		rchk(`TFW_A_CDN, 8'h01);
		@(posedge clk_i);
		frame_end <= 8'h03;
		@(posedge clk_i);
		frame_end <= 8'h00;
		for (int i = 0; i < 40 && expired !== 1'b1; i++) @(posedge clk_i);
		#1;
		check({7'h00, expired}, 8'h01);
		check(stop, 8'h00);
		drive(1'b0, 3, 1);
		rchk(`TFW_A_CNT + 16'h0003, 8'h01);
		@(posedge clk_i);
		frame_end <= 8'h03;
		@(posedge clk_i);
		frame_end <= 8'h00;
		@(posedge clk_i);
		#1;
		check(stop, 8'h01);
		i_host.wr(`TFW_A_MASK, `TFW_MASK_ALL);
		repeat (2) @(posedge clk_i);
		#1;
		check({7'h00, armed}, 8'h01);
		i_host.wr(`TFW_A_CDN, 8'h05);
		repeat (2) @(posedge clk_i);
		#1;
		check({stop[6:0], expired}, 8'h00);
		@(posedge clk_i);
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check({7'h00, armed}, 8'h00);
		$display("test guard done");
	endtask
	task automatic finish_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Whole run is about two hundred cycles; this cuts a hang
	initial begin
		#40000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_level();
		t_full();
		t_event();
		t_guard();
		finish_test();
	end
endmodule
